// File: hdl/pcf_params.svh
// Constants for the per-PLL control and status field logic.
`ifndef PCF_PARAMS_SVH
`define PCF_PARAMS_SVH
`define PCF_NUM_PLLS 3
`define PCF_PDIV_W 17
`define PCF_M1_W 17
`define PCF_MINT_W 8
`define PCF_MFRAC_W 18
`define PCF_NDIV_W 11
`define PCF_BW_W 7
`define PCF_DRV_LVPECL 1'h0
`define PCF_DRV_LVDS 1'h1
`define PCF_MODE_LBW 2'h0
`define PCF_MODE_SYN 2'h1
`define PCF_MODE_HBW0 2'h2
`define PCF_MODE_HBW1 2'h3
`define PCF_POL_PIN 2'h0
`define PCF_POL_NONREV 2'h1
`define PCF_POL_REV 2'h2
`define PCF_POL_REG 2'h3
`define PCF_ADC_DIV16 2'h0
`define PCF_ADC_DIV8 2'h1
`define PCF_ADC_DIV4 2'h2
`define PCF_ADC_DIV2 2'h3
`define PCF_DIVEXP_W 3
`define PCF_ADC_EXP_BASE 3'h4
`define PCF_LCKWIN_BASE_US 2
`define PCF_CLK_MHZ 100
`define PCF_LCKWIN_W 13
`endif

// File: hdl/pcf_pkg.sv
// Types shared by the PLL control and status field logic.
`default_nettype none
`include "pcf_params.svh"
package pcf_pkg;
  typedef enum logic [1:0] {
    PCF_LOW_BW,
    PCF_SYNTH,
    PCF_HIGH_BW
  } pcf_mode_t;
  typedef enum logic [1:0] {
    PCF_SEL_PIN,
    PCF_SEL_NONREV,
    PCF_SEL_REV,
    PCF_SEL_REG
  } pcf_policy_t;
  // Control fields of one PLL as software writes them.
  typedef struct packed {
    logic first_output_driver_type;
    logic second_output_driver_type;
    logic [`PCF_PDIV_W-1:0] reference_predivider;
    logic [`PCF_M1_W-1:0] lower_loop_feedback_divider;
    logic [`PCF_MINT_W-1:0] upper_feedback_integer_part;
    logic [`PCF_MFRAC_W-1:0] upper_feedback_fraction_part;
    logic [`PCF_NDIV_W-1:0] output_divider;
    logic [`PCF_BW_W-1:0] internal_operation_settings;
    logic [1:0] operating_mode_field;
    logic first_output_enable;
    logic second_output_enable;
    logic [1:0] input_selection_policy;
    logic input_select_bit;
    logic [1:0] sampling_rate_field;
    logic [1:0] lock_window_field;
    logic reference_doubler_bit;
  } pcf_ctrl_t;
  // Raw condition inputs of one PLL from the analog monitors.
  typedef struct packed {
    logic input_zero_bad;
    logic input_one_bad;
    logic reference_bad;
    logic locked;
    logic out_of_spec;
  } pcf_cond_t;
  // Status fields of one PLL as software reads them.
  typedef struct packed {
    logic active_input_indicator;
    logic frozen_tracking_flag;
    logic input_one_fault_flag;
    logic input_zero_fault_flag;
    logic reference_fault_flag;
    logic pll_locked_flag;
  } pcf_stat_t;
  // Decoded settings handed to the analog side of one PLL.
  typedef struct packed {
    pcf_mode_t mode;
    logic first_lvds;
    logic second_lvds;
    logic first_on;
    logic second_on;
    logic ref_doubled;
    logic [`PCF_DIVEXP_W-1:0] adc_div_exp;
    logic [`PCF_LCKWIN_W-1:0] lock_window_cycles;
  } pcf_decode_t;
endpackage
`default_nettype wire

// File: hdl/pcf_input_select.sv
// Input clock selection and fail-over for one PLL.
`default_nettype none
`include "pcf_params.svh"
module pcf_input_select
  import pcf_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Policy and selection controls.
  input wire logic [1:0] policy_in,
  input wire logic select_bit_in,
  input wire logic select_pin_in,
  // Synchronised input health.
  input wire logic zero_bad_in,
  input wire logic one_bad_in,
  // Selected input.
  output logic active_out
);
  logic active_reg;
  logic active_next;
  logic primary_bad;
  logic active_bad;
  logic other_bad;

  assign active_out = active_reg;

  // Health of the primary, the active and the standby input.
  always_comb begin
    primary_bad = select_bit_in ? one_bad_in : zero_bad_in;
    active_bad = active_reg ? one_bad_in : zero_bad_in;
    other_bad = active_reg ? zero_bad_in : one_bad_in;
  end

  // Next active input according to the selection policy.
  always_comb begin
    active_next = active_reg;
    unique case (policy_in)
      `PCF_POL_PIN: active_next = select_pin_in;
      `PCF_POL_REG: active_next = select_bit_in;
      `PCF_POL_NONREV: begin
        // Stay on whatever input works; leave only when it fails.
        if (active_bad && !other_bad) begin
          active_next = ~active_reg;
        end
      end
      `PCF_POL_REV: begin
        // Return to the primary as soon as it is good again.
        if (!primary_bad) begin
          active_next = select_bit_in;
        end else if (active_bad && !other_bad) begin
          active_next = ~active_reg;
        end
      end
    endcase
  end

  // Active input register follows fail-over.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_reg <= 1'h0;
    end else begin
      active_reg <= active_next;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pcf_top.sv
// Control and status field logic for the three PLLs of the clock translator.
// How it works
// - First output pair driver: 0 gives LVPECL style, 1 gives LVDS style.
// - Second output pair driver: 0 gives LVPECL style, 1 gives LVDS style.
// - Hold 17-bit predivider, 17-bit lower divider, 8-bit integer, 11-bit output divider.
// - Hold an 18-bit fraction paired with the upper integer divider.
// - Mode 00 low bandwidth, 01 synthesizer, 10 or 11 high bandwidth.
// - First output enable bit 0 disables, 1 enables the first pair.
// - Second output enable bit 0 disables, 1 enables the second pair.
// - Policy 00 pin, 01 auto non-revertive, 10 auto revertive, 11 register.
// - Register manual mode: select bit 0 picks input zero, 1 input one.
// - Automatic modes: select bit names the primary input only; the non-revertive policy ignores it.
// - Pin manual mode ignores the select bit and follows the pin.
// - Sampling code 00..11 divides reference by 16, 8, 4, 2.
// - Lock window code 00..11 gives 2, 4, 8, 16 microseconds.
// - Doubler bit doubles the reference before the phase detector.
// - Input zero fault flag is 1 while bad, clears itself when good.
// - Input one fault flag is 1 while bad, clears itself when good.
// - Reference fault flag is 1 while bad, clears itself when good.
// - Lock flag reads 1 when locked and is mirrored on a lock pin.
// - Holdover flag is 1 while out of spec and oscillator is frozen.
// - Active input flag shows the feeding input and follows fail-over.
// - Hold a 7-bit mode dependent internal settings field.
// - Each of three PLLs has its own independent copy of the fields.
`default_nettype none
`include "pcf_params.svh"
module pcf_top
  import pcf_pkg::*;
#(
  parameter int NUM_PLLS = `PCF_NUM_PLLS
)(
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Control field write port, one strobe per PLL.
  input wire logic [NUM_PLLS-1:0] CTRL_WR_IN,
  input wire pcf_ctrl_t CTRL_DATA_IN,
  // Pins and analog monitor conditions per PLL.
  input wire logic [NUM_PLLS-1:0] SELECT_PIN_IN,
  input wire pcf_cond_t [NUM_PLLS-1:0] COND_IN,
  // Readback of control and status fields.
  output pcf_ctrl_t [NUM_PLLS-1:0] CTRL_OUT,
  output pcf_stat_t [NUM_PLLS-1:0] STAT_OUT,
  // Decoded settings to the analog side.
  output pcf_decode_t [NUM_PLLS-1:0] DECODE_OUT,
  // Lock indicator pins.
  output logic [NUM_PLLS-1:0] LOCK_PIN_OUT
);
  localparam int CW = $bits(pcf_cond_t);

  // Every PLL is one independent copy of the same field logic.
  for (genvar p = 0; p < NUM_PLLS; p++) begin : g_pll
    pcf_ctrl_t ctrl_reg;
    pcf_stat_t stat_reg;
    pcf_decode_t decode_reg;
    pcf_decode_t decode_next;
    logic lock_pin_reg;
    logic [CW-1:0] cond_meta_reg;
    logic [CW-1:0] cond_sync_reg;
    logic sel_meta_reg;
    logic sel_sync_reg;
    pcf_cond_t cond;
    logic active;

    assign cond = pcf_cond_t'(cond_sync_reg);

    // Two-stage synchronisers for the asynchronous monitor lines and pin.
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        cond_meta_reg <= '0;
        cond_sync_reg <= '0;
        sel_meta_reg <= 1'h0;
        sel_sync_reg <= 1'h0;
      end else begin
        cond_meta_reg <= COND_IN[p];
        cond_sync_reg <= cond_meta_reg;
        sel_meta_reg <= SELECT_PIN_IN[p];
        sel_sync_reg <= sel_meta_reg;
      end
    end

    // Control fields load whole from the write port; reserved bits are not stored.
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        ctrl_reg <= '0;
      end else if (CTRL_WR_IN[p]) begin
        ctrl_reg <= CTRL_DATA_IN;
      end
    end

    // Fail-over logic picks the input that feeds this PLL.
    pcf_input_select u_sel (
      .clk_in(CLK_IN),
      .rst_in(SYS_RST_IN),
      .policy_in(ctrl_reg.input_selection_policy),
      .select_bit_in(ctrl_reg.input_select_bit),
      .select_pin_in(sel_sync_reg),
      .zero_bad_in(cond.input_zero_bad),
      .one_bad_in(cond.input_one_bad),
      .active_out(active)
    );

    // Status flags follow live conditions and the active input; the write port cannot load them directly.
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        stat_reg <= '0;
      end else begin
        stat_reg.input_zero_fault_flag <= cond.input_zero_bad;
        stat_reg.input_one_fault_flag <= cond.input_one_bad;
        stat_reg.reference_fault_flag <= cond.reference_bad;
        stat_reg.pll_locked_flag <= cond.locked;
        stat_reg.frozen_tracking_flag <= cond.out_of_spec;
        stat_reg.active_input_indicator <= active;
      end
    end

    // Lock pin mirrors the same condition as the lock flag.
    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        lock_pin_reg <= 1'h0;
      end else begin
        lock_pin_reg <= cond.locked;
      end
    end

    // Decode control fields into settings for the analog side.
    always_comb begin
      decode_next = '0;
      unique case (ctrl_reg.operating_mode_field)
        `PCF_MODE_LBW: decode_next.mode = PCF_LOW_BW;
        `PCF_MODE_SYN: decode_next.mode = PCF_SYNTH;
        `PCF_MODE_HBW0, `PCF_MODE_HBW1: decode_next.mode = PCF_HIGH_BW;
      endcase
      decode_next.first_lvds = (ctrl_reg.first_output_driver_type == `PCF_DRV_LVDS);
      decode_next.second_lvds =
        (ctrl_reg.second_output_driver_type == `PCF_DRV_LVDS);
      decode_next.first_on = ctrl_reg.first_output_enable;
      decode_next.second_on = ctrl_reg.second_output_enable;
      decode_next.ref_doubled = ctrl_reg.reference_doubler_bit;
      // Divide exponent: code 00 is 2^4 = 16 down to code 11 is 2^1 = 2.
      decode_next.adc_div_exp = `PCF_ADC_EXP_BASE
        - {1'h0, ctrl_reg.sampling_rate_field};
      // Window in clock cycles: 2 us doubled per code step.
      decode_next.lock_window_cycles = `PCF_LCKWIN_W'(
        (`PCF_LCKWIN_BASE_US * `PCF_CLK_MHZ) << ctrl_reg.lock_window_field);
    end

    always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
        decode_reg <= '0;
      end else begin
        decode_reg <= decode_next;
      end
    end

    assign CTRL_OUT[p] = ctrl_reg;
    assign STAT_OUT[p] = stat_reg;
    assign DECODE_OUT[p] = decode_reg;
    assign LOCK_PIN_OUT[p] = lock_pin_reg;
  end
endmodule
`default_nettype wire

// File: tb/pcf_top_assertions.sv
// Port checker for the field logic, watching PLL zero.
`default_nettype none
`include "pcf_params.svh"
module pcf_top_assertions
  import pcf_pkg::*;
#(
  parameter int NUM_PLLS = 3
)(
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Inputs of the design.
  input wire logic [NUM_PLLS-1:0] CTRL_WR_IN,
  input wire pcf_ctrl_t CTRL_DATA_IN,
  input wire logic [NUM_PLLS-1:0] SELECT_PIN_IN,
  input wire pcf_cond_t [NUM_PLLS-1:0] COND_IN,
  // Outputs of the design.
  input wire pcf_ctrl_t [NUM_PLLS-1:0] CTRL_OUT,
  input wire pcf_stat_t [NUM_PLLS-1:0] STAT_OUT,
  input wire pcf_decode_t [NUM_PLLS-1:0] DECODE_OUT,
  input wire logic [NUM_PLLS-1:0] LOCK_PIN_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic settle_q;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Marks edges whose previous sample already saw reset released.
  always_ff @(posedge CLK_IN) settle_q <= !SYS_RST_IN;
  // A monitor level held for four samples has reached its flag.
  sequence held4(c);
    c [*4];
  endsequence
  property follows(c, f);
    held4(c) |-> f;
  endproperty
  // Selection controls that stay put long enough to act.
  sequence reg_settled;
    ($stable(CTRL_OUT[0]) && CTRL_OUT[0].input_selection_policy == `PCF_POL_REG) [*3];
  endsequence
  sequence pin_settled;
    ($stable({SELECT_PIN_IN[0], CTRL_OUT[0]}) &&
     CTRL_OUT[0].input_selection_policy == `PCF_POL_PIN) [*6];
  endsequence
  a_ctrl_echo: assert property (
    CTRL_WR_IN[0] |=> CTRL_OUT[0] == $past(CTRL_DATA_IN)) else $error("readback wrong");
  a_driver_types: assert property (settle_q |->
    {DECODE_OUT[0].first_lvds, DECODE_OUT[0].second_lvds} == $past({
    CTRL_OUT[0].first_output_driver_type, CTRL_OUT[0].second_output_driver_type}))
    else $error("driver type wrong");
  a_out_enables: assert property (settle_q |->
    {DECODE_OUT[0].first_on, DECODE_OUT[0].second_on} == $past({
    CTRL_OUT[0].first_output_enable, CTRL_OUT[0].second_output_enable}))
    else $error("enable wrong");
  a_mode_map: assert property (settle_q |-> DECODE_OUT[0].mode ==
    ($past(CTRL_OUT[0].operating_mode_field[1]) ? PCF_HIGH_BW :
    pcf_mode_t'($past(CTRL_OUT[0].operating_mode_field)))) else $error("mode wrong");
  a_window_map: assert property (settle_q |-> DECODE_OUT[0].lock_window_cycles ==
    (13'h0C8 << $past(CTRL_OUT[0].lock_window_field))) else $error("window wrong");
  a_adc_map: assert property (settle_q |-> DECODE_OUT[0].adc_div_exp ==
    3'h4 - {1'h0, $past(CTRL_OUT[0].sampling_rate_field)}) else $error("rate wrong");
  a_zero_flag: assert property (
    follows(COND_IN[0].input_zero_bad, STAT_OUT[0].input_zero_fault_flag))
    else $error("zero flag");
  a_fault_clear: assert property (
    follows(!COND_IN[0].input_zero_bad, !STAT_OUT[0].input_zero_fault_flag))
    else $error("zero clear");
  a_one_flag: assert property (
    follows(COND_IN[0].input_one_bad, STAT_OUT[0].input_one_fault_flag)) else $error("one flag");
  a_ref_flag: assert property (
    follows(COND_IN[0].reference_bad, STAT_OUT[0].reference_fault_flag)) else $error("ref flag");
  a_lock_pin: assert property (
    follows(COND_IN[0].locked, LOCK_PIN_OUT[0] && STAT_OUT[0].pll_locked_flag))
    else $error("lock pin");
  a_holdover: assert property (
    follows(COND_IN[0].out_of_spec, STAT_OUT[0].frozen_tracking_flag)) else $error("holdover");
  a_reg_select: assert property (reg_settled |->
    STAT_OUT[0].active_input_indicator == CTRL_OUT[0].input_select_bit) else $error("reg sel");
  a_pin_select: assert property (pin_settled |->
    STAT_OUT[0].active_input_indicator == SELECT_PIN_IN[0]) else $error("pin sel");
endmodule
bind pcf_top pcf_top_assertions #(.NUM_PLLS(NUM_PLLS)) i_pcf_top_assertions (
  .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .CTRL_WR_IN(CTRL_WR_IN),
  .CTRL_DATA_IN(CTRL_DATA_IN), .SELECT_PIN_IN(SELECT_PIN_IN), .COND_IN(COND_IN),
  .CTRL_OUT(CTRL_OUT), .STAT_OUT(STAT_OUT), .DECODE_OUT(DECODE_OUT),
  .LOCK_PIN_OUT(LOCK_PIN_OUT));
`default_nettype wire

// File: tb/pcf_host_model.sv
// Host software model that writes whole control field sets.
`default_nettype none
`include "pcf_params.svh"
module pcf_host_model
  import pcf_pkg::*;
(
  // Clock.
  input wire logic clk_in,
  // Write strobes and data.
  output logic [`PCF_NUM_PLLS-1:0] wr_out,
  output pcf_ctrl_t data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle until software writes.
  initial begin
    wr_out = '0;
    data_out = '0;
  end
  // Writes one PLL; hold keeps the strobe up for a back-to-back write.
  task automatic write(input int p, input pcf_ctrl_t d, input bit hold);
    wr_out = `PCF_NUM_PLLS'(1 << p);
    data_out = d;
    @(posedge clk_in);
    #1;
    if (!hold) begin
      wr_out = '0;
      data_out = ~d;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/pcf_top_tb.sv
// Self-checking bench for the PLL control and status field logic.
`default_nettype none
`include "pcf_params.svh"
module pcf_top_tb
  import pcf_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int p; pcf_ctrl_t c;} pcf_note_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] wr, lock_q, w1 = '0, w2 = '0, pin = '0;
  logic [5:0] steps [8] = '{6'h13, 6'h11, 6'h20, 6'h29, 6'h30, 6'h39, 6'h08, 6'h05};
  pcf_ctrl_t data, d, last [3];
  pcf_cond_t c;
  pcf_cond_t [2:0] cond = '0;
  pcf_ctrl_t [2:0] ctrl_q;
  pcf_stat_t [2:0] stat_q;
  pcf_decode_t [2:0] dec_q;
  pcf_note_t q1[$], q2[$], n;
  int fails = 0;
  int n_compared = 0;
  // Clock at 100 MHz.
  always #5 clk = ~clk;
  // Design and host model.
  pcf_top #(.NUM_PLLS(3)) i_pcf_top (.CLK_IN(clk), .SYS_RST_IN(rst), .CTRL_WR_IN(wr),
    .CTRL_DATA_IN(data), .SELECT_PIN_IN(pin), .COND_IN(cond), .CTRL_OUT(ctrl_q),
    .STAT_OUT(stat_q), .DECODE_OUT(dec_q), .LOCK_PIN_OUT(lock_q));
  pcf_host_model i_pcf_host_model (.clk_in(clk), .wr_out(wr), .data_out(data));
  // Compares one result and counts it.
  task automatic check(input string what, input logic [95:0] e, input logic [95:0] g);
    n_compared++;
    if (e !== g) begin
      fails++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  // Decoded settings expected for a stored control set.
  function automatic pcf_decode_t exp_dec(pcf_ctrl_t k);
    pcf_decode_t e;
    e.mode = k.operating_mode_field[1] ? PCF_HIGH_BW : pcf_mode_t'(k.operating_mode_field);
    e.first_lvds = k.first_output_driver_type;
    e.second_lvds = k.second_output_driver_type;
    e.first_on = k.first_output_enable;
    e.second_on = k.second_output_enable;
    e.ref_doubled = k.reference_doubler_bit;
    e.adc_div_exp = 3'h4 - {1'h0, k.sampling_rate_field};
    e.lock_window_cycles = 13'h0C8 << k.lock_window_field;
    return e;
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Delays the write strobes to the readback and decode latencies.
  always @(posedge clk) begin
    w1 <= wr;
    w2 <= w1;
  end
  // Takes the oldest note off each queue as its result appears.
  always @(negedge clk) begin
    if (w2 != '0) begin
      n = q2.pop_front();
      check("decode", exp_dec(n.c), dec_q[n.p]);
    end
    if (w1 != '0) begin
      n = q1.pop_front();
      check("ctrl", n.c, ctrl_q[n.p]);
      q2.push_back(n);
    end
  end
  // Cuts a hang short far beyond the expected run of about 150 cycles.
  initial begin
    #50000;
    fails++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    void'($urandom(57542));
    repeat (12) @(posedge clk);
    #1 rst = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    for (int p = 0; p < 3; p++) begin
      check("reset ctrl", '0, ctrl_q[p]);
      check("reset decode", exp_dec('0), dec_q[p]);
      check("reset stat", '0, stat_q[p]);
    end
    for (int i = 0; i < 12; i++) begin
      d = 92'({$urandom, $urandom, $urandom});
      d.operating_mode_field = i[1:0];
      d.sampling_rate_field = i[1:0];
      d.lock_window_field = i[1:0];
      q1.push_back('{i % 3, d});
      last[i % 3] = d;
      i_pcf_host_model.write(i % 3, d, i != 11);
    end
    repeat (3) @(posedge clk);
    #1;
    for (int p = 0; p < 3; p++) check("kept", last[p], ctrl_q[p]);
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 3; k++) begin
        c = pcf_cond_t'(k == 0 ? 5'h1F : (k == 1 ? 5'($urandom) : 5'h00));
        cond[p] = c;
        repeat (5) @(posedge clk);
        #1;
        check("stat", {c.out_of_spec, c.input_one_bad, c.input_zero_bad, c.reference_bad,
          c.locked}, stat_q[p][4:0]);
        check("lock pin", c.locked, lock_q[p]);
      end
    end
    foreach (steps[s]) begin
      d = '0;
      {d.input_selection_policy, d.input_select_bit} = steps[s][5:3];
      q1.push_back('{0, d});
      i_pcf_host_model.write(0, d, 1'h0);
      pin[0] = steps[s][2];
      cond[0].input_zero_bad = steps[s][1];
      repeat (8) @(posedge clk);
      #1;
      check("active", steps[s][0], stat_q[0].active_input_indicator);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
